// ---- common/sfd_defines.vh ----
// Constants for the stepper fault supervision block
`ifndef SFD_DEFINES_VH
`define SFD_DEFINES_VH
// Short check delay and blanking, in ns, and cycle counts at 100 MHz
`define SFD_CLK_PERIOD_NS 10
`define SFD_BLANK_NS 1400
`define SFD_SHORT_CHECK_DELAY_NS 500
`define SFD_MINON_CYC ((`SFD_BLANK_NS + `SFD_SHORT_CHECK_DELAY_NS + `SFD_CLK_PERIOD_NS - 1) / `SFD_CLK_PERIOD_NS)
`define SFD_CNT_W 8
// Translator Home position and one microstep increment
`define SFD_HOME_POS 5'h00
`define SFD_STEP_ONE 5'h01
// Number of bridge phases
`define SFD_PHASES 2
// Low-load threshold in percent of peak trip current
`define SFD_LOW_LOAD_PCT 7'd35
// Fault flag codes {one_n, two_n}, active low
`define SFD_CODE_NONE 2'b11
`define SFD_CODE_SHORT 2'b10
`define SFD_CODE_LOWLOAD 2'b01
`define SFD_CODE_SUPPLY 2'b00
// Bridge drive modes
`define SFD_DRV_OFF 2'b00
`define SFD_DRV_ON 2'b01
`define SFD_DRV_SAFE 2'b10
`endif

// ---- rtl/sfd_short_retry.v ----
// Per-phase short-circuit sampling and retry at each step
`timescale 1ns/1ps
`include "sfd_defines.vh"
module sfd_short_retry (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Control
    input wire step_pulse,
    input wire run,
    input wire short_sense,
    // Status
    output reg phase_off_r,
    output reg short_seen_r
);
    reg [`SFD_CNT_W-1:0] blank_cnt_r;

    // Blanking count, sampling, and lock-off until next step
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blank_cnt_r <= {`SFD_CNT_W{1'b0}};
            phase_off_r <= 1'b0;
            short_seen_r <= 1'b0;
        end else if (!run) begin
            blank_cnt_r <= {`SFD_CNT_W{1'b0}};
            phase_off_r <= 1'b0;
            short_seen_r <= 1'b0;
        end else if (step_pulse) begin
            phase_off_r <= 1'b0;
            blank_cnt_r <= {`SFD_CNT_W{1'b0}};
        end else if (!phase_off_r) begin
            if (blank_cnt_r < `SFD_MINON_CYC) begin
                blank_cnt_r <= blank_cnt_r + 1'b1;
            end else if (short_sense) begin
                phase_off_r <= 1'b1;
                short_seen_r <= 1'b1;
            end else begin
                short_seen_r <= 1'b0;
            end
        end
    end
endmodule

// ---- rtl/sfd_low_load.v ----
// Low-load detection at the Home microstep position
`timescale 1ns/1ps
`include "sfd_defines.vh"
module sfd_low_load (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Control
    input wire preset,
    input wire step_rise,
    input wire at_home,
    input wire [6:0] phase_a_pct,
    input wire [6:0] phase_b_pct,
    // Status
    output reg low_load_r
);
    reg home_low_r;
    wire both_ok;

    assign both_ok = (phase_a_pct > `SFD_LOW_LOAD_PCT) && (phase_b_pct > `SFD_LOW_LOAD_PCT);

    // Verdict measured at Home, reported on the next step edge
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            home_low_r <= 1'b1;
            low_load_r <= 1'b1;
        end else if (preset) begin
            home_low_r <= 1'b1;
            low_load_r <= 1'b1;
        end else begin
            if (at_home) begin
                home_low_r <= !both_ok;
            end
            // Flag only updates at Home, so it holds between visits
            if (step_rise && at_home) begin
                low_load_r <= home_low_r;
            end
        end
    end
endmodule

// ---- rtl/sfd_top.v ----
// Fault supervision of a microstepping bipolar motor driver
`timescale 1ns/1ps
`include "sfd_defines.vh"
module sfd_top (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Host controls
    input wire step_in,
    input wire dir_in,
    input wire sleep_n,
    // Analog monitor results
    input wire main_overvoltage,
    input wire regulator_undervoltage,
    input wire logic_undervoltage,
    input wire over_temp,
    input wire short_sense_a,
    input wire short_sense_b,
    input wire [6:0] phase_a_pct,
    input wire [6:0] phase_b_pct,
    // Fault flags, active low
    output reg fault_flag_one_n,
    output reg fault_flag_two_n,
    // Bridge drive state
    output reg [1:0] bridge_a_mode_r,
    output reg [1:0] bridge_b_mode_r,
    output reg [4:0] microstep_r
);
    localparam ST_SLEEP = 2'b00;
    localparam ST_RUN = 2'b01;
    localparam ST_UV = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg step_d_r;
    reg preset_r;
    wire step_rise;
    wire run;
    wire at_home;
    wire off_a;
    wire off_b;
    wire sc_a;
    wire sc_b;
    wire [`SFD_PHASES-1:0] sense_v;
    wire [`SFD_PHASES-1:0] off_v;
    wire [`SFD_PHASES-1:0] sc_v;
    wire low_load;
    wire uv;
    wire [1:0] code;

    assign uv = regulator_undervoltage | logic_undervoltage;
    assign step_rise = step_in & ~step_d_r;
    assign run = (state_r == ST_RUN);
    assign at_home = (microstep_r == `SFD_HOME_POS);

    // Phase sense gathered into a vector for the per-phase loop
    assign sense_v = {short_sense_b, short_sense_a};
    assign off_a = off_v[0];
    assign off_b = off_v[1];
    assign sc_a = sc_v[0];
    assign sc_b = sc_v[1];

    // Power state sequencing
    always @* begin
        case (state_r)
            ST_SLEEP: state_nxt = !sleep_n ? ST_SLEEP : (uv ? ST_UV : ST_RUN);
            ST_RUN: state_nxt = uv ? ST_UV : (!sleep_n ? ST_SLEEP : ST_RUN);
            ST_UV: state_nxt = uv ? ST_UV : (!sleep_n ? ST_SLEEP : ST_RUN);
            default: state_nxt = ST_SLEEP;
        endcase
    end

    // State, step edge, and preset on entering run
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_SLEEP;
            step_d_r <= 1'b0;
            preset_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            step_d_r <= step_in;
            preset_r <= !run;
        end
    end

    // Translator position; Home held outside run
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            microstep_r <= `SFD_HOME_POS;
        end else if (!run) begin
            microstep_r <= `SFD_HOME_POS;
        end else if (step_rise) begin
            if (dir_in) begin
                microstep_r <= microstep_r + `SFD_STEP_ONE;
            end else begin
                microstep_r <= microstep_r - `SFD_STEP_ONE;
            end
        end
    end

    // One short sampler per bridge phase; each locks only its own phase
    genvar ph;
    generate
        for (ph = 0; ph < `SFD_PHASES; ph = ph + 1) begin : gen_phase
            sfd_short_retry u_short (
                .sys_clk(sys_clk),
                .rst(rst),
                .step_pulse(step_rise),
                .run(run),
                .short_sense(sense_v[ph]),
                .phase_off_r(off_v[ph]),
                .short_seen_r(sc_v[ph])
            );
        end
    endgenerate

    sfd_low_load u_low_load (
        .sys_clk(sys_clk),
        .rst(rst),
        .preset(preset_r),
        .step_rise(step_rise),
        .at_home(at_home),
        .phase_a_pct(phase_a_pct),
        .phase_b_pct(phase_b_pct),
        .low_load_r(low_load)
    );

    // Fault class priority: supply, short, low-load
    assign code = (main_overvoltage | uv | state_r == ST_UV) ? `SFD_CODE_SUPPLY :
                  (sc_a | sc_b) ? `SFD_CODE_SHORT :
                  (low_load | preset_r) ? `SFD_CODE_LOWLOAD :
                  `SFD_CODE_NONE;

    // Registered flags and bridge modes
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_flag_one_n <= 1'b0;
            fault_flag_two_n <= 1'b0;
            bridge_a_mode_r <= `SFD_DRV_OFF;
            bridge_b_mode_r <= `SFD_DRV_OFF;
        end else begin
            fault_flag_one_n <= code[1];
            fault_flag_two_n <= code[0];
            if (main_overvoltage) begin
                bridge_a_mode_r <= `SFD_DRV_SAFE;
                bridge_b_mode_r <= `SFD_DRV_SAFE;
            end else if (!run || uv || over_temp) begin
                bridge_a_mode_r <= `SFD_DRV_OFF;
                bridge_b_mode_r <= `SFD_DRV_OFF;
            end else begin
                // Open load keeps drive on
                bridge_a_mode_r <= off_a ? `SFD_DRV_OFF : `SFD_DRV_ON;
                bridge_b_mode_r <= off_b ? `SFD_DRV_OFF : `SFD_DRV_ON;
            end
        end
    end
endmodule

// ---- test/sfd_assertions.sv ----
// Port-level checker for the fault supervision block
`timescale 1ns/1ps
module sfd_checker (
    // Clock and reset
    input logic sys_clk, rst,
    // Host and monitor inputs
    input logic step_in, dir_in, sleep_n, main_overvoltage, regulator_undervoltage,
    input logic logic_undervoltage, over_temp, short_sense_a, short_sense_b,
    input logic [6:0] phase_a_pct, phase_b_pct,
    // Flags and drive state
    input logic fault_flag_one_n, fault_flag_two_n,
    input logic [1:0] bridge_a_mode_r, bridge_b_mode_r,
    input logic [4:0] microstep_r
);
    // Combined undervoltage and flag code
    wire uv = regulator_undervoltage | logic_undervoltage;
    wire [1:0] ff = {fault_flag_one_n, fault_flag_two_n};
    wire ok = sleep_n & !uv & !main_overvoltage;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_OV_SAFE: assert property ((main_overvoltage && !uv)[*3] |->
        bridge_a_mode_r == 2'h2 && bridge_b_mode_r == 2'h2 && ff == 2'h0) else $error("ov");
    AST_UV_RESET: assert property (uv[*3] |-> bridge_a_mode_r == 2'h0 &&
        bridge_b_mode_r == 2'h0 && microstep_r == 5'h00 && ff == 2'h0) else $error("uv");
    AST_OT_OFF: assert property ((over_temp && !main_overvoltage)[*3] |->
        bridge_a_mode_r == 2'h0 && bridge_b_mode_r == 2'h0) else $error("ot");
    AST_SLEEP_HOME: assert property ((!sleep_n)[*3] |-> microstep_r == 5'h00)
        else $error("sleep");
    AST_WAKE_PRESET: assert property ($rose(sleep_n) && !main_overvoltage && !uv |->
        ##2 ff == 2'h1) else $error("wake");
    AST_STEP_MOVE: assert property ($rose(step_in) && ok |=> microstep_r -
        $past(microstep_r) == ($past(dir_in) ? 5'h01 : 5'h1f)) else $error("step");
    AST_LOW_LOAD: assert property ($rose(step_in) && ok && microstep_r == 5'h00 &&
        (phase_a_pct <= 7'h23 || phase_b_pct <= 7'h23) |-> ##2 ff == 2'h1) else $error("ll");
    AST_GOOD_LOAD: assert property ($rose(step_in) && ok && microstep_r == 5'h00 &&
        phase_a_pct > 7'h23 && phase_b_pct > 7'h23 |-> ##2 ff == 2'h3) else $error("gl");
    AST_LL_HOLD: assert property (ff == 2'h1 && microstep_r != 5'h00 &&
        $past(microstep_r) != 5'h00 && ok && !over_temp && !short_sense_a && !short_sense_b
        |=> ff == 2'h1) else $error("hold");
endmodule
bind sfd_top sfd_checker u_chk (.sys_clk, .rst, .step_in, .dir_in, .sleep_n,
    .main_overvoltage, .regulator_undervoltage, .logic_undervoltage, .over_temp,
    .short_sense_a, .short_sense_b, .phase_a_pct, .phase_b_pct, .fault_flag_one_n,
    .fault_flag_two_n, .bridge_a_mode_r, .bridge_b_mode_r, .microstep_r);

// ---- test/sfd_host_model.sv ----
// Host controller model issuing step pulses
`timescale 1ns/1ps
module sfd_host_model (
    // Clock
    input wire logic sys_clk,
    // Step line to the driver
    output logic step_in
);
    // Step line idles low
    initial step_in = 1'b0;
    // One pulse: high two cycles, low two, spaced for slow stepping
    task pulse;
        begin
            @(posedge sys_clk);
            #1 step_in = 1'b1;
            repeat (2) @(posedge sys_clk);
            #1 step_in = 1'b0;
            repeat (2) @(posedge sys_clk);
            #1;
        end
    endtask
endmodule

// ---- test/sfd_tb_top.sv ----
// Self-checking bench for the fault supervision block
`timescale 1ns/1ps
module stepper_fault_diagnostics_tb_top;
    logic sys_clk, rst, step_in, dir_in, sleep_n, main_overvoltage, regulator_undervoltage;
    logic logic_undervoltage, over_temp, short_sense_a, short_sense_b;
    logic fault_flag_one_n, fault_flag_two_n;
    logic [6:0] phase_a_pct, phase_b_pct;
    logic [1:0] bridge_a_mode_r, bridge_b_mode_r;
    logic [4:0] microstep_r;
    int mismatches = 0;
    int checks_done = 0;
    wire [4:0] ffw = {3'h0, fault_flag_one_n, fault_flag_two_n};
    wire [4:0] bam = {3'h0, bridge_a_mode_r};
    wire [4:0] bbm = {3'h0, bridge_b_mode_r};
    // Rows: phase A, phase B, flags after a step leaving Home
    logic [15:0] rows [5] = '{{7'h14, 7'h46, 2'h1}, {7'h46, 7'h46, 2'h3},
        {7'h46, 7'h23, 2'h1}, {7'h24, 7'h24, 2'h3}, {7'h23, 7'h24, 2'h1}};
    sfd_top dut (.sys_clk, .rst, .step_in, .dir_in, .sleep_n, .main_overvoltage,
        .regulator_undervoltage, .logic_undervoltage, .over_temp, .short_sense_a,
        .short_sense_b, .phase_a_pct, .phase_b_pct, .fault_flag_one_n, .fault_flag_two_n,
        .bridge_a_mode_r, .bridge_b_mode_r, .microstep_r);
    sfd_host_model host (.sys_clk, .step_in);
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Compare and count
    task chk(input string what, input logic [4:0] exp, input logic [4:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Wait cycles, then step off the edge
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Counts and verdict
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        stop_test();
    end
    // Main sequence
    initial begin
        {rst, dir_in, sleep_n, main_overvoltage, regulator_undervoltage} = 5'h14;
        {logic_undervoltage, over_temp, short_sense_a, short_sense_b} = 4'h0;
        {phase_a_pct, phase_b_pct} = {7'h46, 7'h46};
        cyc(20);
        rst = 1'b0;
        cyc(2);
        chk("reset flags", 5'h01, ffw);
        chk("reset step", 5'h00, microstep_r);
        $display("test reset done");
        foreach (rows[i]) begin
            {phase_a_pct, phase_b_pct} = rows[i][15:2];
            dir_in = 1'b1;
            host.pulse();
            chk("home verdict", {3'h0, rows[i][1:0]}, ffw);
            dir_in = 1'b0;
            host.pulse();
            chk("held flags", {3'h0, rows[i][1:0]}, ffw);
            chk("back home", 5'h00, microstep_r);
        end
        $display("test load rows done");
        short_sense_a = 1'b1;
        dir_in = 1'b1;
        host.pulse();
        chk("bridge a blank", 5'h01, bam);
        cyc(200);
        chk("bridge a off", 5'h00, bam);
        chk("bridge b on", 5'h01, bbm);
        chk("short code", 5'h02, ffw);
        host.pulse();
        chk("bridge a retry", 5'h01, bam);
        short_sense_a = 1'b0;
        cyc(200);
        chk("short cleared", 5'h01, ffw);
        $display("test short done");
        main_overvoltage = 1'b1;
        cyc(3);
        chk("ov bridge", 5'h02, bam);
        chk("ov flags", 5'h00, ffw);
        main_overvoltage = 1'b0;
        over_temp = 1'b1;
        cyc(3);
        chk("ot bridge", 5'h00, bbm);
        over_temp = 1'b0;
        cyc(3);
        chk("ot release", 5'h01, bbm);
        $display("test ov ot done");
        for (int k = 1; k < 3; k++) begin
            {regulator_undervoltage, logic_undervoltage} = k[1:0];
            cyc(3);
            chk("uv step", 5'h00, microstep_r);
            chk("uv flags", 5'h00, ffw);
            chk("uv bridge", 5'h00, bam);
            {regulator_undervoltage, logic_undervoltage} = 2'h0;
            cyc(3);
            chk("uv preset", 5'h01, ffw);
        end
        $display("test uv done");
        {phase_a_pct, phase_b_pct} = {7'h46, 7'h46};
        host.pulse();
        chk("first step", 5'h03, ffw);
        sleep_n = 1'b0;
        cyc(3);
        chk("sleep step", 5'h00, microstep_r);
        sleep_n = 1'b1;
        cyc(3);
        chk("wake flags", 5'h01, ffw);
        host.pulse();
        chk("wake step", 5'h03, ffw);
        $display("test sleep done");
        stop_test();
    end
endmodule
